/* File: design/serial_flash_pin_interface.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_pin_cfg.svh"

module serial_flash_pin_interface #(
  parameter int PAGES = `PAGE_COUNT
) (
  input wire logic clk, // 200 MHz system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic clkEn, // freezes all state when low
  input wire logic selectN, // device select pin, low active
  input wire logic serialClk, // serial clock pin
  input wire logic [3:0] ioIn, // data pins as seen on the wire
  output logic [3:0] ioOut, // data pin drive values
  output logic [3:0] ioOe, // data pin drive enables
  input wire flash_pin_pkg::xfer_type xferMode, // core phase
  input wire logic [7:0] txByte, // next byte to send
  input wire logic progBusy, // internal program or erase
  input wire logic [PAGES-1:0] lockInit, // stored page locks
  input wire logic lockReq, // lock a page, pulse
  input wire logic progReq, // program a page, pulse
  input wire logic [1:0] pageSel, // security page index
  output logic [7:0] rxByte, // received byte
  output logic rxValid, // rxByte new, pulse
  output logic txTaken, // txByte consumed, pulse
  output logic frameStart, // frame opened, pulse
  output logic frameEnd, // frame closed, pulse
  output logic standby, // device in standby
  output logic writeProtect, // hardware protection held
  output logic [PAGES-1:0] pageLocked, // page lock state
  output logic progRefused // page program refused, pulse
);

  logic [5:0] pinS;
  logic selN;
  logic sclk;
  logic [3:0] ioS;
  logic sclkPrev;
  logic next_sclkPrev;
  logic rise;
  logic fall;
  logic pauseLow;

  flash_pin_pkg::link_type state;
  flash_pin_pkg::link_type next_state;
  logic next_standby;

  logic [7:0] rxShift;
  logic [7:0] next_rxShift;
  logic [3:0] rxCount;
  logic [3:0] next_rxCount;
  logic [7:0] next_rxByte;
  logic next_rxValid;
  logic [7:0] txShift;
  logic [7:0] next_txShift;
  logic [3:0] txCount;
  logic [3:0] next_txCount;
  logic [7:0] txCur;
  logic next_txTaken;
  logic [3:0] next_ioOut;
  logic [3:0] next_ioOe;
  logic next_frameStart;
  logic next_frameEnd;
  logic next_writeProtect;
  logic [3:0] lanes;
  logic inFrame;
  logic nextInFrame;

  pin_sync #(
    .WIDTH(`PIN_COUNT),
    .RESET_VAL(`PIN_RESET)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .din({selectN, serialClk, ioIn}),
    .dout(pinS)
  );

  security_page_lock #(
    .PAGES(PAGES)
  ) u_lock (
    .clk(clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .lockInit(lockInit),
    .lockReq(lockReq),
    .progReq(progReq),
    .pageSel(pageSel),
    .pageLocked(pageLocked),
    .progRefused(progRefused)
  );

  assign selN = pinS[5];
  assign sclk = pinS[4];
  assign ioS = pinS[3:0];
  assign rise = sclk && !sclkPrev;
  assign fall = !sclk && sclkPrev;
  assign lanes = flash_pin_pkg::laneCount(xferMode);
  // line three is the pause input only outside quad phases
  assign pauseLow = !ioS[3] && !flash_pin_pkg::isQuad(xferMode);
  assign inFrame = (state == flash_pin_pkg::LINK_ACTIVE) ||
                   (state == flash_pin_pkg::LINK_PAUSED);
  assign nextInFrame = (next_state == flash_pin_pkg::LINK_ACTIVE) ||
                       (next_state == flash_pin_pkg::LINK_PAUSED);

  always_comb
  begin
    next_state = state;
    unique case (state)
      flash_pin_pkg::LINK_IDLE:
      begin
        if (!selN)
          next_state = flash_pin_pkg::LINK_ACTIVE;
      end
      flash_pin_pkg::LINK_ACTIVE, flash_pin_pkg::LINK_PAUSED:
      begin
        if (selN)
          next_state = progBusy ? flash_pin_pkg::LINK_FINISH
                                : flash_pin_pkg::LINK_IDLE;
        else if (state == flash_pin_pkg::LINK_ACTIVE && pauseLow && !sclk)
          next_state = flash_pin_pkg::LINK_PAUSED;
        else if (state == flash_pin_pkg::LINK_PAUSED && !pauseLow)
          next_state = flash_pin_pkg::LINK_ACTIVE;
      end
      flash_pin_pkg::LINK_FINISH:
      begin
        if (!selN)
          next_state = flash_pin_pkg::LINK_ACTIVE;
        else if (!progBusy)
          next_state = flash_pin_pkg::LINK_IDLE;
      end
    endcase
    next_standby = (next_state == flash_pin_pkg::LINK_IDLE);
    next_sclkPrev = sclk;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state <= flash_pin_pkg::LINK_IDLE;
      standby <= 1'b1;
      sclkPrev <= 1'b0;
    end
    else if (clkEn)
    begin
      state <= next_state;
      standby <= next_standby;
      sclkPrev <= next_sclkPrev;
    end
  end

  always_comb
  begin
    next_rxShift = rxShift;
    next_rxCount = rxCount;
    next_rxByte = rxByte;
    next_rxValid = 1'b0;
    next_txShift = txShift;
    next_txCount = txCount;
    next_txTaken = 1'b0;
    next_ioOut = ioOut;
    next_ioOe = 4'h0;
    next_frameStart = 1'b0;
    next_frameEnd = 1'b0;
    next_writeProtect = writeProtect;
    txCur = (txCount == 4'h0) ? txByte : txShift;
    if (!inFrame && nextInFrame)
    begin
      // fresh frame: drop any partial byte of the last one
      next_frameStart = 1'b1;
      next_rxCount = 4'h0;
      next_txCount = 4'h0;
    end
    if (inFrame && !nextInFrame)
      next_frameEnd = 1'b1;
    // edges count only while selected and not paused
    if (state == flash_pin_pkg::LINK_ACTIVE &&
        next_state == flash_pin_pkg::LINK_ACTIVE)
    begin
      if (rise && !flash_pin_pkg::drivesOut(xferMode))
      begin
        if (xferMode == flash_pin_pkg::XFER_QUAD_IN)
          next_rxShift = {rxShift[3:0], ioS};
        else
          next_rxShift = {rxShift[6:0], ioS[0]};
        next_rxCount = rxCount + lanes;
        if (next_rxCount == `BYTE_BITS)
        begin
          next_rxByte = next_rxShift;
          next_rxValid = 1'b1;
          next_rxCount = 4'h0;
        end
      end
      if (fall && flash_pin_pkg::drivesOut(xferMode))
      begin
        next_txTaken = (txCount == 4'h0);
        unique case (xferMode)
          flash_pin_pkg::XFER_DUAL_OUT:
            next_ioOut[1:0] = txCur[7:6];
          flash_pin_pkg::XFER_QUAD_OUT:
            next_ioOut = txCur[7:4];
          default:
            next_ioOut[1] = txCur[7];
        endcase
        next_txShift = txCur << lanes;
        next_txCount = txCount + lanes;
        if (next_txCount == `BYTE_BITS)
          next_txCount = 4'h0;
      end
    end
    // host must have released its lanes by now
    if (next_state == flash_pin_pkg::LINK_ACTIVE)
      next_ioOe = flash_pin_pkg::laneOe(xferMode);
    // quad phases borrow line two, so the last level holds
    if (!flash_pin_pkg::isQuad(xferMode))
      next_writeProtect = !ioS[2];
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rxShift <= `SHIFT_RESET;
      rxCount <= 4'h0;
      rxByte <= `SHIFT_RESET;
      rxValid <= 1'b0;
      txShift <= `SHIFT_RESET;
      txCount <= 4'h0;
      txTaken <= 1'b0;
      ioOut <= 4'h0;
      ioOe <= 4'h0;
      frameStart <= 1'b0;
      frameEnd <= 1'b0;
      writeProtect <= 1'b0;
    end
    else if (clkEn)
    begin
      rxShift <= next_rxShift;
      rxCount <= next_rxCount;
      rxByte <= next_rxByte;
      rxValid <= next_rxValid;
      txShift <= next_txShift;
      txCount <= next_txCount;
      txTaken <= next_txTaken;
      ioOut <= next_ioOut;
      ioOe <= next_ioOe;
      frameStart <= next_frameStart;
      frameEnd <= next_frameEnd;
      writeProtect <= next_writeProtect;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence endWhileBusy;
    clkEn && selN && progBusy && state == flash_pin_pkg::LINK_ACTIVE;
  endsequence
  sequence endIdle;
    clkEn && selN && !progBusy && inFrame;
  endsequence

  chk_frame_open: assert property (
    (clkEn && !selN && state == flash_pin_pkg::LINK_IDLE)
    |=> (frameStart && state == flash_pin_pkg::LINK_ACTIVE))
    else $error("frame did not open on select low");

  chk_standby_enter: assert property (
    endIdle |=> (standby && frameEnd))
    else $error("no standby after release");

  chk_standby_wait: assert property (
    endWhileBusy |=> (!standby && state == flash_pin_pkg::LINK_FINISH))
    else $error("standby entered while busy");

  chk_rx_rise: assert property (
    (rxValid && $past(clkEn)) |-> $past(rise))
    else $error("byte completed off a rising edge");

  chk_tx_fall: assert property (
    ($past(clkEn) && ioOut != $past(ioOut)) |-> $past(fall))
    else $error("output changed off a falling edge");

  chk_ignore_idle: assert property (
    (clkEn && selN && state == flash_pin_pkg::LINK_IDLE)
    |=> ($stable(rxShift) && !rxValid))
    else $error("input taken while deselected");

  chk_float_idle: assert property (
    (clkEn && selN) |=> ioOe == 4'h0)
    else $error("output driven while deselected");

  chk_dual_lanes: assert property (
    (clkEn && next_state == flash_pin_pkg::LINK_ACTIVE &&
     xferMode == flash_pin_pkg::XFER_DUAL_OUT) |=> ioOe == 4'h3)
    else $error("dual read lanes wrong");

  chk_quad_in: assert property (
    (clkEn && rise && state == flash_pin_pkg::LINK_ACTIVE &&
     next_state == flash_pin_pkg::LINK_ACTIVE &&
     xferMode == flash_pin_pkg::XFER_QUAD_IN && rxCount == 4'h4)
    |=> (rxValid && ioOe == 4'h0))
    else $error("quad input byte not complete after two edges");

  chk_quad_lanes: assert property (
    (clkEn && next_state == flash_pin_pkg::LINK_ACTIVE &&
     xferMode == flash_pin_pkg::XFER_QUAD_OUT) |=> ioOe == 4'hf)
    else $error("quad read lanes wrong");

  chk_wp_hold: assert property (
    (clkEn && flash_pin_pkg::isQuad(xferMode)) |=> $stable(writeProtect))
    else $error("write protect moved during quad phase");
  chk_pause_quiet: assert property (
    (state == flash_pin_pkg::LINK_PAUSED && $past(clkEn))
    |-> (ioOe == 4'h0 && !rxValid && !standby))
    else $error("pause did not float or kept sampling");

endmodule : serial_flash_pin_interface
`default_nettype wire

/* File: inc/flash_pin_cfg.svh */
`ifndef FLASH_PIN_CFG_SVH
`define FLASH_PIN_CFG_SVH

// pin sampling: {selectN, serialClk, io[3:0]}
`define PIN_COUNT 6
// reset at idle pin levels: select high, both pulled-up lines high,
// so write protect does not flicker on after reset
`define PIN_RESET 6'h2c
`define BYTE_BITS 4'h8
`define SHIFT_RESET 8'h00
`define PAGE_COUNT 3
`define LOCK_RESET 3'h0

`endif

/* File: inc/flash_pin_pkg.sv */
package flash_pin_pkg;

  typedef enum logic [2:0] {
    XFER_CMD = 3'b000,
    XFER_SINGLE_OUT = 3'b001,
    XFER_DUAL_OUT = 3'b010,
    XFER_QUAD_OUT = 3'b011,
    XFER_QUAD_IN = 3'b100
  } xfer_type;

  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_ACTIVE = 2'b01,
    LINK_PAUSED = 2'b10,
    LINK_FINISH = 2'b11
  } link_type;

  function automatic logic [3:0] laneCount(input xfer_type m);
    case (m)
      XFER_DUAL_OUT: laneCount = 4'h2;
      XFER_QUAD_OUT, XFER_QUAD_IN: laneCount = 4'h4;
      default: laneCount = 4'h1;
    endcase
  endfunction : laneCount

  function automatic logic isQuad(input xfer_type m);
    isQuad = (m == XFER_QUAD_OUT) || (m == XFER_QUAD_IN);
  endfunction : isQuad

  function automatic logic drivesOut(input xfer_type m);
    drivesOut = (m == XFER_SINGLE_OUT) || (m == XFER_DUAL_OUT) ||
                (m == XFER_QUAD_OUT);
  endfunction : drivesOut

  function automatic logic [3:0] laneOe(input xfer_type m);
    case (m)
      XFER_SINGLE_OUT: laneOe = 4'h2;
      XFER_DUAL_OUT: laneOe = 4'h3;
      XFER_QUAD_OUT: laneOe = 4'hf;
      default: laneOe = 4'h0;
    endcase
  endfunction : laneOe

endpackage : flash_pin_pkg

/* File: design/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_pin_cfg.svh"

module pin_sync #(
  parameter int WIDTH = `PIN_COUNT,
  parameter logic [WIDTH-1:0] RESET_VAL = `PIN_RESET
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic clkEn, // freezes state when low
  input wire logic [WIDTH-1:0] din, // asynchronous pins
  output logic [WIDTH-1:0] dout // second stage
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_dout;

  // first stage feeds only the second
  always_comb
  begin
    next_stage1 = din;
    next_dout = stage1;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      stage1 <= RESET_VAL;
      dout <= RESET_VAL;
    end
    else if (clkEn)
    begin
      stage1 <= next_stage1;
      dout <= next_dout;
    end
  end

endmodule : pin_sync
`default_nettype wire

/* File: design/security_page_lock.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_pin_cfg.svh"

module security_page_lock #(
  parameter int PAGES = `PAGE_COUNT
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic clkEn, // freezes state when low
  input wire logic [PAGES-1:0] lockInit, // stored lock bits
  input wire logic lockReq, // lock pageSel, pulse
  input wire logic progReq, // program pageSel, pulse
  input wire logic [1:0] pageSel, // page index
  output logic [PAGES-1:0] pageLocked, // lock state
  output logic progRefused // program refused, pulse
);

  logic [PAGES-1:0] next_pageLocked;
  logic next_progRefused;
  logic selValid;

  always_comb
  begin
    selValid = 32'(pageSel) < PAGES;
    next_pageLocked = pageLocked;
    next_progRefused = 1'b0;
    // each page locks alone and never unlocks
    if (lockReq && selValid)
    begin
      next_pageLocked[pageSel] = 1'b1;
    end
    if (progReq)
    begin
      next_progRefused = !selValid || pageLocked[pageSel];
    end
  end

  // reset reloads the stored state, not a blank
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pageLocked <= lockInit;
      progRefused <= 1'b0;
    end
    else if (clkEn)
    begin
      pageLocked <= next_pageLocked;
      progRefused <= next_progRefused;
    end
  end

  chk_lock_sticky: assert property (
    @(posedge clk) disable iff (sys_rst)
    (pageLocked & ~$past(pageLocked)) == '0 || $past(lockReq))
    else $error("page lock bit set without request");

  chk_locked_refuse: assert property (
    @(posedge clk) disable iff (sys_rst)
    (clkEn && progReq && pageSel < 2'h3 && pageLocked[pageSel])
    |=> progRefused)
    else $error("program of locked page not refused");

endmodule : security_page_lock
`default_nettype wire

/* File: testbench/host_spi_model.sv */
`timescale 1ns/1ps
`default_nettype none

module host_spi_model (
  input wire logic clk, // system clock, float pattern only
  input wire logic [3:0] devOut, // device drive values
  input wire logic [3:0] devOe, // device drive enables
  output logic selectN, // device select, low active
  output logic serialClk, // serial clock
  output logic [3:0] ioWire // resolved line levels
);
  localparam int HALF = 40;
  logic [3:0] hostOut = 4'h0;
  logic [3:0] hostOe = 4'h0;
  logic tog = 1'h0;

  initial
  begin
    selectN = 1'h1;
    serialClk = 1'h0;
  end

  always @(posedge clk) tog <= ~tog;

  // lines 2 and 3 have pull-ups; 0 and 1 float to a moving pattern
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (devOe[i])
        ioWire[i] = devOut[i];
      else if (hostOe[i])
        ioWire[i] = hostOut[i];
      else
        ioWire[i] = (i > 1) ? 1'h1 : tog ^ (i == 1);
    end
  end

  task automatic select(input logic on);
    #1.7;
    serialClk = 1'h0;
    selectN = ~on;
    #HALF;
  endtask : select

  task automatic shiftOut(input logic [7:0] b, input int lanes);
    logic [7:0] d;
    d = b;
    #1.7;
    for (int n = 0; n < 8 / lanes; n++)
    begin
      serialClk = 1'h0;
      hostOe = (lanes == 4) ? 4'hf : 4'h1;
      hostOut = (lanes == 4) ? d[7:4] : {3'h0, d[7]};
      d = (lanes == 4) ? {d[3:0], 4'h0} : {d[6:0], 1'h0};
      #HALF;
      serialClk = 1'h1;
      #10;
      // early release leaves the device a turnaround before a read
      if (n == 8 / lanes - 1)
        hostOe = 4'h0;
      #(HALF - 10);
    end
  endtask : shiftOut

  task automatic shiftIn(input int lanes, output logic [7:0] b);
    #1.7;
    hostOe = 4'h0;
    b = 8'h00;
    // an idle-low clock is raised first; output phases ignore rises
    if (!serialClk)
    begin
      serialClk = 1'h1;
      #HALF;
    end
    for (int n = 0; n < 8 / lanes; n++)
    begin
      serialClk = 1'h0;
      #HALF;
      serialClk = 1'h1;
      case (lanes)
        1: b = {b[6:0], ioWire[1]};
        2: b = {b[5:0], ioWire[1:0]};
        default: b = {b[3:0], ioWire};
      endcase
      #HALF;
    end
  endtask : shiftIn

  task automatic tick;
    #1.7;
    serialClk = 1'h1;
    #HALF;
    serialClk = 1'h0;
    #HALF;
  endtask : tick

  task automatic setLine(input int i, input logic oe, input logic v);
    #1.7;
    hostOe[i] = oe;
    hostOut[i] = v;
  endtask : setLine
endmodule : host_spi_model

`default_nettype wire

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic clkEn = 1'h1;
  logic selectN;
  logic serialClk;
  logic [3:0] ioWire;
  logic [3:0] ioOut;
  logic [3:0] ioOe;
  flash_pin_pkg::xfer_type xferMode = flash_pin_pkg::XFER_CMD;
  logic [7:0] txByte = 8'h00;
  logic progBusy = 1'h0;
  logic lockReq = 1'h0;
  logic progReq = 1'h0;
  logic [1:0] pageSel = 2'h0;
  logic [7:0] rxByte;
  logic rxValid;
  logic txTaken;
  logic frameStart;
  logic frameEnd;
  logic standby;
  logic writeProtect;
  logic [2:0] pageLocked;
  logic progRefused;
  logic [7:0] lastRx = 8'h00;
  int rxCnt = 0;
  int startCnt = 0;
  int endCnt = 0;
  int refCnt = 0;
  int takeCnt = 0;
  int cycles = 0;
  int failCount = 0;
  int nTests = 0;

  always #2.5 clk = ~clk;

  serial_flash_pin_interface u_dut (.clk(clk), .sys_rst(sys_rst),
    .clkEn(clkEn), .selectN(selectN), .serialClk(serialClk),
    .ioIn(ioWire), .ioOut(ioOut), .ioOe(ioOe), .xferMode(xferMode),
    .txByte(txByte), .progBusy(progBusy), .lockInit(3'h4),
    .lockReq(lockReq), .progReq(progReq), .pageSel(pageSel),
    .rxByte(rxByte), .rxValid(rxValid), .txTaken(txTaken),
    .frameStart(frameStart), .frameEnd(frameEnd), .standby(standby),
    .writeProtect(writeProtect), .pageLocked(pageLocked),
    .progRefused(progRefused));

  host_spi_model u_host (.clk(clk), .devOut(ioOut), .devOe(ioOe),
    .selectN(selectN), .serialClk(serialClk), .ioWire(ioWire));

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (rxValid === 1'h1)
    begin
      rxCnt <= rxCnt + 1;
      lastRx <= rxByte;
    end
    if (frameStart === 1'h1)
      startCnt <= startCnt + 1;
    if (frameEnd === 1'h1)
      endCnt <= endCnt + 1;
    if (progRefused === 1'h1)
      refCnt <= refCnt + 1;
    if (txTaken === 1'h1)
      takeCnt <= takeCnt + 1;
    if (cycles == 20000)
    begin
      failCount++;
      endSim();
    end
  end

  task automatic endSim;
    if (failCount == 0 && nTests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : endSim

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      failCount++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // #1 lets the edge's register updates land before sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic openCmd(input logic [7:0] cmd);
    int s;
    s = startCnt;
    u_host.select(1'h1);
    check(8'(startCnt - s), 8'h01);
    check({7'h0, standby}, 8'h00);
    s = rxCnt;
    u_host.shiftOut(cmd, 1);
    cyc(1);
    check(8'(rxCnt - s), 8'h01);
    check(lastRx, cmd);
  endtask : openCmd

  task automatic closeFrame;
    int e;
    e = endCnt;
    u_host.select(1'h0);
    cyc(6);
    check(8'(endCnt - e), 8'h01);
    check({4'h0, ioOe}, 8'h00);
    check({7'h0, standby}, {7'h0, ~progBusy});
    @(posedge clk);
    xferMode <= flash_pin_pkg::XFER_CMD;
  endtask : closeFrame

  task automatic tIdle;
    int s;
    s = rxCnt;
    for (int k = 0; k < 8; k++)
    begin
      u_host.setLine(0, 1'h1, k[0]);
      cyc(4);
    end
    // clocked bits while deselected must not land
    u_host.shiftOut(8'ha5, 1);
    u_host.setLine(0, 1'h0, 1'h0);
    check(8'(rxCnt - s), 8'h00);
    check({4'h0, ioOe}, 8'h00);
  endtask : tIdle

  task automatic tRead;
    logic [7:0] got;
    logic [7:0] pat [3] = '{8'h3c, 8'h96, 8'h5a};
    logic [3:0] oe [3] = '{4'h2, 4'h3, 4'hf};
    int t;
    for (int m = 0; m < 3; m++)
    begin
      openCmd(8'h0b);
      @(posedge clk);
      xferMode <= flash_pin_pkg::xfer_type'(3'(m + 1));
      txByte <= pat[m];
      cyc(2);
      check({4'h0, ioOe}, {4'h0, oe[m]});
      t = takeCnt;
      u_host.shiftIn(1 << m, got);
      check(got, pat[m]);
      check(8'(takeCnt - t), 8'h01);
      check({7'h0, writeProtect}, 8'h00);
      closeFrame();
    end
  endtask : tRead

  task automatic tQuadIn;
    int r;
    openCmd(8'h32);
    @(posedge clk);
    xferMode <= flash_pin_pkg::XFER_QUAD_IN;
    cyc(2);
    check({4'h0, ioOe}, 8'h00);
    r = rxCnt;
    u_host.shiftOut(8'hc3, 4);
    cyc(1);
    check(8'(rxCnt - r), 8'h01);
    check(lastRx, 8'hc3);
    check({7'h0, writeProtect}, 8'h00);
    closeFrame();
  endtask : tQuadIn

  task automatic tWp;
    // clock enable low: the pin change must not reach the flag yet
    @(posedge clk);
    clkEn <= 1'h0;
    u_host.setLine(2, 1'h1, 1'h0);
    cyc(5);
    check({7'h0, writeProtect}, 8'h00);
    @(posedge clk);
    clkEn <= 1'h1;
    cyc(5);
    check({7'h0, writeProtect}, 8'h01);
    u_host.setLine(2, 1'h0, 1'h0);
    cyc(5);
    check({7'h0, writeProtect}, 8'h00);
  endtask : tWp

  task automatic tPause;
    logic [7:0] got;
    u_host.select(1'h1);
    @(posedge clk);
    xferMode <= flash_pin_pkg::XFER_SINGLE_OUT;
    txByte <= 8'he1;
    cyc(2);
    check({4'h0, ioOe}, 8'h02);
    u_host.setLine(3, 1'h1, 1'h0);
    cyc(6);
    check({4'h0, ioOe}, 8'h00);
    check({7'h0, standby}, 8'h00);
    // a fall while paused would shift bit 7 out early
    u_host.tick();
    u_host.setLine(3, 1'h0, 1'h0);
    cyc(6);
    check({4'h0, ioOe}, 8'h02);
    u_host.shiftIn(1, got);
    check(got, 8'he1);
    closeFrame();
  endtask : tPause

  task automatic tBusy;
    @(posedge clk);
    progBusy <= 1'h1;
    openCmd(8'h02);
    closeFrame();
    @(posedge clk);
    progBusy <= 1'h0;
    cyc(3);
    check({7'h0, standby}, 8'h01);
  endtask : tBusy

  task automatic tSec;
    int r;
    @(posedge clk);
    lockReq <= 1'h1;
    pageSel <= 2'h1;
    @(posedge clk);
    lockReq <= 1'h0;
    cyc(3);
    check({5'h0, pageLocked}, 8'h06);
    for (int p = 0; p < 4; p++)
    begin
      r = refCnt;
      @(posedge clk);
      progReq <= 1'h1;
      pageSel <= 2'(p);
      @(posedge clk);
      progReq <= 1'h0;
      cyc(3);
      check(8'(refCnt - r), {7'h0, p != 0});
    end
  endtask : tSec

  initial
  begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    cyc(1);
    check({7'h0, standby}, 8'h01);
    check({4'h0, ioOe}, 8'h00);
    check({5'h0, pageLocked}, 8'h04);
    check({7'h0, writeProtect}, 8'h00);
    tIdle();
    tRead();
    tQuadIn();
    tWp();
    tPause();
    tBusy();
    tSec();
    endSim();
  end
endmodule : tb

`default_nettype wire
